//--- cks_clock_synth.sv
// Clock synthesizer configuration registers and digital divider chain
`timescale 1ns/1ps
module cks_clock_synth
  import cks_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic reset,
  input wire logic clock_reset,
  // Reference and mode
  input wire logic reference_clock_in,
  input wire logic full_duplex,
  // Register port
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Generated clocks and rate error flag
  output logic dac_update_clock,
  output logic sample_clock,
  output logic receive_interface_clock,
  output logic aux_clock_out_a,
  output logic aux_clock_out_b,
  output logic rate_config_error
);

  logic [7:0] pll_clock_config;
  logic [7:0] aux_clock_output_config;
  logic [CKS_CHAIN_W-1:0] chain;
  logic [1:0] ref_div;
  logic ref_q;
  logic [1:0] cfg_age;

  // Pick one tap of the divider chain by a two-bit exponent
  function automatic logic cks_tap(input logic [CKS_CHAIN_W-1:0] c, input logic [1:0] e);
    cks_tap = c[e];
  endfunction : cks_tap

  // Field decode
  wire [1:0] mult_exp = pll_clock_config[CKS_MULT_LSB +: 2];
  wire [1:0] div_raw = pll_clock_config[CKS_DIV_LSB +: 2];
  wire src_pll = pll_clock_config[CKS_SAMPLE_SEL_BIT];
  wire [1:0] div_exp = (div_raw == CKS_EXP_RESERVED) ? CKS_EXP_MAX_SAMPLE : div_raw;
  wire [1:0] a_exp = aux_clock_output_config[CKS_A_DIV_LSB +: 2];
  wire a_inv = aux_clock_output_config[CKS_A_INVERT_BIT];
  wire a_dis = aux_clock_output_config[CKS_A_DISABLE_BIT];
  wire [1:0] b_exp = aux_clock_output_config[CKS_B_DIV_LSB +: 2];
  wire b_inv = aux_clock_output_config[CKS_B_INVERT_BIT];
  wire b_dis = aux_clock_output_config[CKS_B_DISABLE_BIT];
  wire ref_rise = reference_clock_in & ~ref_q;

  // Chain bits up to the multiplier exponent span one reference period; only those restart
  // at a reference rise, so the upper bits keep counting and slower taps still run
  logic [CKS_CHAIN_W-1:0] lock_mask;
  for (genvar gi = 0; gi < CKS_CHAIN_W; gi++) begin : g_lock_mask
    assign lock_mask[gi] = (2'(gi) <= mult_exp);
  end
  wire [CKS_CHAIN_W-1:0] next_chain = ref_rise ? (chain + 1'b1) & ~lock_mask : chain + 1'b1;

  // Word-rate tap: divider output or the reference rate (chain tap at the multiplier exponent)
  wire [1:0] word_exp = src_pll ? div_exp : mult_exp;
  wire rx_tap_bad = full_duplex && (word_exp == CKS_EXP_ZERO);
  wire [1:0] rx_exp = (full_duplex && !rx_tap_bad) ? word_exp - CKS_EXP_ONE : word_exp;

  // Next values of the generated clocks
  wire next_dac = chain[0];
  wire next_sample = src_pll ? cks_tap(chain, div_exp) : ref_q;
  wire next_rx = (!src_pll && !full_duplex) ? ref_q : cks_tap(chain, rx_exp);
  wire next_aux_a = ~a_dis & (cks_tap(chain, a_exp) ^ a_inv);
  wire b_src = (b_exp == CKS_EXP_ZERO) ? ref_q :
               (b_exp == CKS_EXP_ONE) ? ref_div[0] : ref_div[1];
  wire next_aux_b = ~b_dis & (b_src ^ b_inv);
  wire [1:0] next_cfg_age = reg_write ? CKS_EXP_ZERO :
                            (cfg_age == CKS_CFG_SETTLED) ? cfg_age : cfg_age + CKS_EXP_ONE;
  wire [7:0] next_rdata =
    (reg_addr == CKS_PLL_CLOCK_CONFIG_ADDR) ? pll_clock_config :
    (reg_addr == CKS_AUX_CLOCK_OUTPUT_CONFIG_ADDR) ? aux_clock_output_config :
    CKS_READ_UNMAPPED;

  // Configuration registers; the device reset clears these only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pll_clock_config <= CKS_PLL_CLOCK_CONFIG_RESET;
      aux_clock_output_config <= CKS_AUX_CLOCK_OUTPUT_CONFIG_RESET;
      reg_rdata <= CKS_READ_UNMAPPED;
      cfg_age <= CKS_EXP_ZERO;
    end else begin
      if (reg_write && reg_addr == CKS_PLL_CLOCK_CONFIG_ADDR) begin
        pll_clock_config <= reg_wdata;
      end
      if (reg_write && reg_addr == CKS_AUX_CLOCK_OUTPUT_CONFIG_ADDR) begin
        aux_clock_output_config <= reg_wdata;
      end
      if (reg_read) begin
        reg_rdata <= next_rdata;
      end
      cfg_age <= next_cfg_age;
    end
  end

  // Divider chain; reset by power-up only so clocks survive a device reset
  // Restarting at each reference rise fixes the output phase against the reference
  always_ff @(posedge clk or posedge clock_reset) begin
    if (clock_reset) begin
      chain <= '0;
      ref_q <= 1'b0;
      ref_div <= 2'h0;
    end else begin
      ref_q <= reference_clock_in;
      chain <= next_chain;
      ref_div <= ref_rise ? ref_div + 2'h1 : ref_div;
    end
  end

  // Clock outputs straight from flops, outside the device reset
  always_ff @(posedge clk or posedge clock_reset) begin
    if (clock_reset) begin
      dac_update_clock <= 1'b0;
      sample_clock <= 1'b0;
      receive_interface_clock <= 1'b0;
      aux_clock_out_a <= 1'b0;
      aux_clock_out_b <= 1'b0;
      rate_config_error <= 1'b0;
    end else begin
      dac_update_clock <= next_dac;
      sample_clock <= next_sample;
      receive_interface_clock <= next_rx;
      aux_clock_out_a <= next_aux_a;
      aux_clock_out_b <= next_aux_b;
      rate_config_error <= rx_tap_bad;
    end
  end

  // Checks wait two edges after any write so that new settings have reached every output
  wire settled = (cfg_age == CKS_CFG_SETTLED) && !reset;

  a_aux_a_disable: assert property (@(posedge clk) disable iff (clock_reset)
    settled && a_dis |=> !aux_clock_out_a)
    else $error("output A not held low while disabled");

  a_aux_b_disable: assert property (@(posedge clk) disable iff (clock_reset)
    settled && b_dis |=> !aux_clock_out_b)
    else $error("output B not held low while disabled");

  a_aux_b_copy: assert property (@(posedge clk) disable iff (clock_reset)
    settled && !b_dis && b_exp == CKS_EXP_ZERO |=>
      aux_clock_out_b == ($past(reference_clock_in, 2) ^ $past(b_inv)))
    else $error("output B is not the delayed reference");

  a_aux_a_fast: assert property (@(posedge clk) disable iff (clock_reset)
    settled && !a_dis && a_exp == CKS_EXP_ZERO && !$past(ref_rise) |=>
      aux_clock_out_a != $past(aux_clock_out_a))
    else $error("output A at divide one does not toggle");

  a_aux_a_invert: assert property (@(posedge clk) disable iff (clock_reset)
    settled && !a_dis |=> aux_clock_out_a == ($past(chain[a_exp]) ^ $past(a_inv)))
    else $error("output A wrong tap or polarity");

  a_sample_ref: assert property (@(posedge clk) disable iff (clock_reset)
    settled && !src_pll |=> sample_clock == $past(reference_clock_in, 2))
    else $error("sample clock not the buffered reference");

  a_sample_reserved: assert property (@(posedge clk) disable iff (clock_reset)
    settled && src_pll && div_raw == CKS_EXP_RESERVED |=> sample_clock == $past(chain[2]))
    else $error("reserved divide not treated as four");

  a_chain_lock: assert property (@(posedge clk) disable iff (clock_reset)
    ref_rise |=> ((chain & $past(lock_mask)) == '0) ##1 chain[0])
    else $error("divider chain not restarted by reference edge");

  a_clock_in_reset: assert property (@(posedge clk) disable iff (clock_reset)
    reset && !ref_rise ##1 reset |-> dac_update_clock != $past(dac_update_clock))
    else $error("update clock stopped during device reset");

  a_rx_double: assert property (@(posedge clk) disable iff (clock_reset)
    settled && full_duplex && src_pll && div_exp == CKS_EXP_ONE |=>
      receive_interface_clock == $past(chain[0]))
    else $error("receive clock not twice the word rate");

  a_dac_toggle: assert property (@(posedge clk) disable iff (clock_reset)
    settled && !$past(ref_rise) |=> dac_update_clock != $past(dac_update_clock))
    else $error("update clock missed a half period");

  a_sample_divided: assert property (@(posedge clk) disable iff (clock_reset)
    settled && src_pll && div_raw != CKS_EXP_RESERVED |=>
      sample_clock == $past(chain[div_raw]))
    else $error("divided sample clock on the wrong tap");

  a_aux_b_half: assert property (@(posedge clk) disable iff (clock_reset)
    settled && !b_dis && b_exp == CKS_EXP_ONE |=>
      aux_clock_out_b == ($past(ref_div[0]) ^ $past(b_inv)))
    else $error("output B at divide two is not the halved reference");

  a_aux_b_quarter: assert property (@(posedge clk) disable iff (clock_reset)
    settled && !b_dis && b_exp == CKS_EXP_MAX_SAMPLE |=>
      aux_clock_out_b == ($past(ref_div[1]) ^ $past(b_inv)))
    else $error("output B at divide four is not the quartered reference");

  a_rx_half_duplex: assert property (@(posedge clk) disable iff (clock_reset)
    settled && !full_duplex |=> receive_interface_clock == sample_clock)
    else $error("half-duplex receive clock differs from the sample clock");

  a_rate_error: assert property (@(posedge clk) disable iff (clock_reset)
    settled && full_duplex && word_exp == CKS_EXP_ZERO |=> rate_config_error)
    else $error("full duplex at the fastest word tap not flagged");

endmodule : cks_clock_synth

//--- cks_pkg.sv
// Constants for the clock synthesizer configuration and divider block
package cks_pkg;
  // Register offsets
  localparam logic [7:0] CKS_PLL_CLOCK_CONFIG_ADDR = 8'h04;
  localparam logic [7:0] CKS_AUX_CLOCK_OUTPUT_CONFIG_ADDR = 8'h06;
  // Reset values
  localparam logic [7:0] CKS_PLL_CLOCK_CONFIG_RESET = 8'h00;
  localparam logic [7:0] CKS_AUX_CLOCK_OUTPUT_CONFIG_RESET = 8'h00;
  localparam logic [7:0] CKS_READ_UNMAPPED = 8'h00;
  // Synthesizer register fields
  localparam int CKS_MULT_LSB = 0;
  localparam int CKS_DIV_LSB = 2;
  localparam int CKS_SAMPLE_SEL_BIT = 4;
  // Output-control register fields
  localparam int CKS_A_DISABLE_BIT = 0;
  localparam int CKS_A_INVERT_BIT = 1;
  localparam int CKS_A_DIV_LSB = 2;
  localparam int CKS_B_DISABLE_BIT = 4;
  localparam int CKS_B_INVERT_BIT = 5;
  localparam int CKS_B_DIV_LSB = 6;
  // Divider chain width, exponent codes and settle count
  localparam int CKS_CHAIN_W = 4;
  localparam logic [1:0] CKS_EXP_ZERO = 2'h0;
  localparam logic [1:0] CKS_EXP_ONE = 2'h1;
  localparam logic [1:0] CKS_EXP_MAX_SAMPLE = 2'h2;
  localparam logic [1:0] CKS_EXP_RESERVED = 2'h3;
  localparam logic [1:0] CKS_CFG_SETTLED = 2'h2;
endpackage : cks_pkg

//--- cks_clock_meter.sv
// Back-end model that consumes the generated clocks and measures their periods
`timescale 1ns/1ps
module cks_clock_meter (
  // Clock and reset
  input wire logic clk,
  input wire logic clock_reset,
  // Clocks consumed by the back end
  input wire logic [4:0] clks,
  // Periods in clk cycles
  output logic [7:0] per [5]
);
  logic [4:0] prev;
  logic [7:0] cnt [5];
  // Cycles between rises; a stopped clock keeps the old figure, so levels are checked apart
  always_ff @(posedge clk or posedge clock_reset) begin
    if (clock_reset) begin
      prev <= 5'h00;
      for (int i = 0; i < 5; i++) begin
        cnt[i] <= 8'h00;
        per[i] <= 8'h00;
      end
    end else begin
      prev <= clks;
      for (int i = 0; i < 5; i++) begin
        cnt[i] <= (clks[i] && !prev[i]) ? 8'h01 : cnt[i] + 8'h01;
        if (clks[i] && !prev[i]) per[i] <= cnt[i];
      end
    end
  end
endmodule : cks_clock_meter

//--- clock_synth_divider_control_tb_top.sv
// Testbench for the clock synthesizer configuration and divider block
`timescale 1ns/1ps
module clock_synth_divider_control_tb_top;
  import cks_pkg::*;
  logic clk, reset, clock_reset, ref_clk, full_duplex, reg_write, reg_read;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, x0, x1, seen;
  logic dac, smp, rxc, ca, cb, err;
  logic [7:0] per [5];
  int error_cnt = 0, cmp_count = 0, cyc = 0, rc = 0, ref_half = 1;
  cks_clock_synth DUT (.clk(clk), .reset(reset), .clock_reset(clock_reset),
    .reference_clock_in(ref_clk), .full_duplex(full_duplex), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .dac_update_clock(dac), .sample_clock(smp), .receive_interface_clock(rxc),
    .aux_clock_out_a(ca), .aux_clock_out_b(cb), .rate_config_error(err));
  cks_clock_meter meter (.clk(clk), .clock_reset(clock_reset),
    .clks({rxc, cb, ca, smp, dac}), .per(per));
  // 200 MHz clock; reference tracks the multiplier setting so the host keeps it legal
  always #2.5 clk = ~clk;
  always @(negedge clk) begin
    rc <= (rc >= ref_half - 1) ? 0 : rc + 1;
    if (rc >= ref_half - 1) ref_clk <= ~ref_clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) {reg_write, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk) reg_write = 1'b0;
    repeat (40) @(negedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) {reg_read, reg_addr} = {1'b1, a};
    @(negedge clk) reg_read = 1'b0;
    chk("rdata", reg_rdata, e);
  endtask : rd
  task automatic test_done();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // Main sequence
  initial begin
    {clk, reset, clock_reset, ref_clk, full_duplex, reg_write, reg_read} = 7'h30;
    {reg_addr, reg_wdata} = 16'h0000;
    repeat (20) @(negedge clk);
    {reset, clock_reset} = 2'b00;
    rd(CKS_PLL_CLOCK_CONFIG_ADDR, CKS_PLL_CLOCK_CONFIG_RESET);
    rd(CKS_AUX_CLOCK_OUTPUT_CONFIG_ADDR, CKS_AUX_CLOCK_OUTPUT_CONFIG_RESET);
    rd(8'h05, CKS_READ_UNMAPPED);
    for (int m = 0; m < 4; m++) begin
      ref_half = 1 << m;
      wr(CKS_PLL_CLOCK_CONFIG_ADDR, 8'(m));
      chk("dac", per[0], 8'h02);
      chk("smp", per[1], 8'(2 << m));
    end
    ref_half = 1;
    for (int n = 0; n < 4; n++) begin
      wr(CKS_PLL_CLOCK_CONFIG_ADDR, 8'(16 + 4 * n));
      rd(CKS_PLL_CLOCK_CONFIG_ADDR, 8'(16 + 4 * n));
      chk("smp", per[1], 8'(2 << ((n == 3) ? 2 : n)));
    end
    for (int r = 0; r < 4; r++) begin
      wr(CKS_AUX_CLOCK_OUTPUT_CONFIG_ADDR, 8'(4 * r + 64 * (r % 3)));
      chk("aux_a", per[2], 8'(2 << r));
      chk("aux_b", per[3], 8'(2 << (r % 3)));
    end
    wr(CKS_AUX_CLOCK_OUTPUT_CONFIG_ADDR, 8'h00);
    x0 = {6'h00, ca ^ dac, cb ^ dac};
    wr(CKS_AUX_CLOCK_OUTPUT_CONFIG_ADDR, 8'h22);
    x1 = {6'h00, ca ^ dac, cb ^ dac};
    chk("invert", x1, x0 ^ 8'h03);
    for (int k = 0; k < 2; k++) begin
      wr(CKS_AUX_CLOCK_OUTPUT_CONFIG_ADDR, k ? 8'h33 : 8'h11);
      seen = 8'h00;
      repeat (16) @(negedge clk) seen = seen | {6'h00, ca, cb};
      chk("disabled", seen, 8'h00);
    end
    wr(CKS_PLL_CLOCK_CONFIG_ADDR, 8'h14);
    for (int fd = 0; fd < 2; fd++) begin
      full_duplex = fd[0];
      wr(CKS_AUX_CLOCK_OUTPUT_CONFIG_ADDR, 8'h00);
      chk("receive_interface_clock", per[4], fd ? 8'h02 : 8'h04);
      chk("rate_err", {7'h00, err}, 8'h00);
    end
    wr(CKS_PLL_CLOCK_CONFIG_ADDR, 8'h10);
    chk("rate_err", {7'h00, err}, 8'h01);
    // Reference-sourced word rate in full duplex: receive clock at twice the reference
    ref_half = 4;
    wr(CKS_PLL_CLOCK_CONFIG_ADDR, 8'h02);
    chk("receive_interface_clock", per[4], 8'h04);
    chk("rate_err", {7'h00, err}, 8'h00);
    full_duplex = 1'b0;
    ref_half = 1;
    wr(CKS_PLL_CLOCK_CONFIG_ADDR, 8'h00);
    // Slower settings first, so the figures after reset prove both outputs still run
    wr(CKS_AUX_CLOCK_OUTPUT_CONFIG_ADDR, 8'h44);
    reset = 1'b1;
    repeat (40) @(negedge clk);
    chk("aux_a", per[2], 8'h02);
    chk("aux_b", per[3], 8'h02);
    reset = 1'b0;
    test_done();
  end
endmodule : clock_synth_divider_control_tb_top
